// ==== logic/dcbd_decoder.sv ====
// Command block collector, decoder and status return of the disk controller

module dcbd_decoder (
  input  wire logic                   clk_i,         // System clock
  input  wire logic                   arst_n_i,      // Async reset, low
  input  wire logic                   cmd_valid_i,   // Command byte offered
  input  wire logic [7:0]             cmd_byte_i,    // Command byte
  output logic                        cmd_ready_o,   // Command byte taken
  output logic                        out_valid_o,   // Reply byte offered
  output logic [7:0]                  out_byte_o,    // Reply byte
  output logic                        out_sense_o,   // Reply byte is sense data
  output logic                        out_last_o,    // Last reply byte
  input  wire logic                   out_ready_i,   // Host takes reply byte
  input  wire logic                   drive_ready_i, // Selected drive ready
  input  wire logic                   track0_i,      // Selected drive at track 00
  input  wire logic                   xfer_err_i,    // Pulse: sector error seen
  input  wire logic [20:0]            xfer_addr_i,   // Sector or track address
  output dcbd_pkg::dcbd_cmd_type      cmd_o,         // Decoded command block
  output dcbd_pkg::dcbd_opt_type      opt_o,         // Decoded control options
  output logic                        drive_sel_o,   // Selected drive number
  output logic                        step_o,        // Step pulse to drive
  output logic                        cmd_busy_o     // Command in progress
);

  // ---------------------------------------------------------------
  // State and storage
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_COLLECT = 3'b000,
    ST_EXEC    = 3'b001,
    ST_SEEK    = 3'b010,
    ST_SENSE   = 3'b011,
    ST_STATUS  = 3'b100
  } dcbd_state_type;

  dcbd_state_type state_q;
  logic [7:0]  blk_q [dcbd_pkg::BLOCK_LEN];
  logic [2:0]  idx_q;
  logic [1:0]  sidx_q;
  logic        stat_idx_q;
  logic [5:0]  code_q;
  logic        addr_valid_q;
  logic [20:0] err_addr_q;
  logic        seek_start_q;
  logic [7:0]  out_byte_q;
  dcbd_pkg::dcbd_cmd_type cmd_q;

  // ---------------------------------------------------------------
  // Reply byte builders
  // ---------------------------------------------------------------
  function automatic logic [7:0] sense_byte(input logic [1:0]  sel,
                                            input logic        valid,
                                            input logic [5:0]  code,
                                            input logic [20:0] addr);
    logic [7:0] b;
    b = dcbd_pkg::BYTE_ZERO;
    case (sel)
      2'h0: begin
        b                          = {2'b00, code};
        b[dcbd_pkg::SN_VALID_BIT]  = valid;
      end
      2'h1: b = {3'b000, addr[20:16]};
      2'h2: b = addr[15:8];
      default: b = addr[7:0];
    endcase
    return b;
  endfunction

  // First status byte: unit and error flag, all else zero
  function automatic logic [7:0] status_byte(input logic unit,
                                             input logic err);
    logic [7:0] b;
    b                        = dcbd_pkg::BYTE_ZERO;
    b[dcbd_pkg::ST_UNIT_BIT] = unit;
    b[dcbd_pkg::ST_ERR_BIT]  = err;
    return b;
  endfunction

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire logic byte_take  = (state_q == ST_COLLECT) && cmd_valid_i;
  wire logic block_full = byte_take && (idx_q == dcbd_pkg::IDX_LAST);
  wire logic out_take   = out_valid_o && out_ready_i;
  wire logic class_ok   = (cmd_q.cmd_class == dcbd_pkg::CLASS_DATA) ||
                          (cmd_q.cmd_class == dcbd_pkg::CLASS_DIAG);
  wire logic is_data    = (cmd_q.cmd_class == dcbd_pkg::CLASS_DATA);
  wire logic op_ready   = is_data && (cmd_q.opcode == dcbd_pkg::OP_TEST_RDY);
  wire logic op_recal   = is_data && (cmd_q.opcode == dcbd_pkg::OP_RECAL);
  wire logic op_sense   = is_data && (cmd_q.opcode == dcbd_pkg::OP_SENSE);
  wire logic seek_done;
  wire logic seek_fail;
  wire logic seek_busy;
  wire logic [7:0] status_ok;
  wire logic [7:0] status_bad;
  wire logic [7:0] status_rdy;
  wire logic [7:0] status_seek;
  wire logic [7:0] sense_next;

  // Fields from stored bytes; don't-care positions simply never read
  always_comb begin
    cmd_q.cmd_class         = blk_q[dcbd_pkg::IDX_CLS_OP][7:5];
    cmd_q.opcode            = blk_q[dcbd_pkg::IDX_CLS_OP][4:0];
    cmd_q.drive_unit_number = blk_q[dcbd_pkg::IDX_UNIT_HI][7:5];
    cmd_q.block_addr        = {blk_q[dcbd_pkg::IDX_UNIT_HI][4:0],
                               blk_q[dcbd_pkg::IDX_MID],
                               blk_q[dcbd_pkg::IDX_LOW]};
    cmd_q.count             = blk_q[dcbd_pkg::IDX_COUNT];
    cmd_q.control           = blk_q[dcbd_pkg::IDX_CTRL];
  end

  assign cmd_o              = cmd_q;
  assign opt_o.half_step_a  = cmd_q.control[dcbd_pkg::CTL_HALF_A];
  assign opt_o.half_step_b  = cmd_q.control[dcbd_pkg::CTL_HALF_B];
  assign opt_o.buffered     = cmd_q.control[dcbd_pkg::CTL_BUF_STEP];
  assign opt_o.no_reread    = cmd_q.control[dcbd_pkg::CTL_NO_REREAD];
  assign opt_o.no_retry     = cmd_q.control[dcbd_pkg::CTL_NO_RETRY];
  // Spare control bits 3..5 are not decoded (host keeps them zero)
  assign drive_sel_o        = cmd_q.drive_unit_number[0];

  // Candidate reply bytes for the reply register
  assign status_ok   = status_byte(drive_sel_o, 1'b0);
  assign status_bad  = status_byte(drive_sel_o, 1'b1);
  assign status_rdy  = status_byte(drive_sel_o, !drive_ready_i);
  assign status_seek = status_byte(drive_sel_o, seek_fail);
  assign sense_next  = sense_byte(sidx_q + 2'h1, addr_valid_q, code_q, err_addr_q);

  assign cmd_ready_o = (state_q == ST_COLLECT);
  assign out_valid_o = (state_q == ST_SENSE) || (state_q == ST_STATUS);
  assign out_byte_o  = out_byte_q;
  assign out_sense_o = (state_q == ST_SENSE);
  assign out_last_o  = (state_q == ST_STATUS) && stat_idx_q;
  assign cmd_busy_o  = (state_q != ST_COLLECT);

  // ---------------------------------------------------------------
  // Stepping
  // ---------------------------------------------------------------
  dcbd_stepper u_stepper (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .start_i  (seek_start_q),
    .opt_i    (opt_o),
    .track0_i (track0_i),
    .step_o   (step_o),
    .busy_o   (seek_busy),
    .done_o   (seek_done),
    .fail_o   (seek_fail)
  );

  // ---------------------------------------------------------------
  // Command block storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < dcbd_pkg::BLOCK_LEN; i++) begin
        blk_q[i] <= dcbd_pkg::BYTE_ZERO;
      end
    end else if (byte_take) begin
      blk_q[idx_q] <= cmd_byte_i;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q      <= ST_COLLECT;
      idx_q        <= 3'h0;
      sidx_q       <= 2'h0;
      stat_idx_q   <= 1'b0;
      code_q       <= dcbd_pkg::ERR_NONE;
      addr_valid_q <= 1'b0;
      err_addr_q   <= 21'h000000;
      seek_start_q <= 1'b0;
      out_byte_q   <= dcbd_pkg::BYTE_ZERO;
    end else begin
      seek_start_q <= 1'b0;
      // Failing sector or track address from the transfer engine
      if (xfer_err_i) begin
        err_addr_q <= xfer_addr_i;
      end
      case (state_q)
        ST_COLLECT: begin
          if (byte_take) begin
            idx_q <= block_full ? 3'h0 : idx_q + 3'h1;
          end
          if (block_full) begin
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (!class_ok || !(op_ready || op_recal || op_sense)) begin
            code_q       <= dcbd_pkg::ERR_INVALID;
            addr_valid_q <= 1'b0;
            state_q      <= ST_STATUS;
            out_byte_q   <= status_bad;
          end else if (op_ready) begin
            code_q       <= drive_ready_i ? dcbd_pkg::ERR_NONE : dcbd_pkg::ERR_NOT_RDY;
            addr_valid_q <= 1'b0;
            state_q      <= ST_STATUS;
            out_byte_q   <= status_rdy;
          end else if (op_recal) begin
            seek_start_q <= 1'b1;
            state_q      <= ST_SEEK;
          end else begin
            sidx_q     <= 2'h0;
            state_q    <= ST_SENSE;
            out_byte_q <= sense_byte(2'h0, addr_valid_q, code_q, err_addr_q);
          end
          stat_idx_q <= 1'b0;
        end
        ST_SEEK: begin
          if (seek_done || seek_fail) begin
            code_q       <= seek_fail ? dcbd_pkg::ERR_NO_TRK0 : dcbd_pkg::ERR_NONE;
            addr_valid_q <= 1'b0;
            state_q      <= ST_STATUS;
            out_byte_q   <= status_seek;
          end else if (!seek_busy && !seek_start_q) begin
            seek_start_q <= 1'b1;
          end
        end
        ST_SENSE: begin
          if (out_take) begin
            if (sidx_q == dcbd_pkg::SENSE_LAST) begin
              state_q    <= ST_STATUS;
              out_byte_q <= status_ok;
            end else begin
              sidx_q     <= sidx_q + 2'h1;
              out_byte_q <= sense_next;
            end
          end
        end
        ST_STATUS: begin
          if (out_take) begin
            if (stat_idx_q) begin
              state_q    <= ST_COLLECT;
              stat_idx_q <= 1'b0;
            end else begin
              stat_idx_q <= 1'b1;
              out_byte_q <= dcbd_pkg::BYTE_ZERO;
            end
          end
        end
        default: state_q <= ST_COLLECT;
      endcase
    end
  end

endmodule

// ==== logic/dcbd_pkg.sv ====
// Package: constants and types of the disk command block decoder
package dcbd_pkg;

  // ---------------------------------------------------------------
  // Command block layout
  // ---------------------------------------------------------------
  localparam int unsigned BLOCK_LEN    = 6;
  localparam int unsigned SENSE_LEN    = 4;
  localparam logic [2:0]  IDX_CLS_OP   = 3'h0;
  localparam logic [2:0]  IDX_UNIT_HI  = 3'h1;
  localparam logic [2:0]  IDX_MID      = 3'h2;
  localparam logic [2:0]  IDX_LOW      = 3'h3;
  localparam logic [2:0]  IDX_COUNT    = 3'h4;
  localparam logic [2:0]  IDX_CTRL     = 3'h5;
  localparam logic [2:0]  IDX_LAST     = 3'h5;
  localparam logic [1:0]  SENSE_LAST   = 2'h3;

  // ---------------------------------------------------------------
  // Classes, opcodes, control bits
  // ---------------------------------------------------------------
  localparam logic [2:0]  CLASS_DATA   = 3'h0;
  localparam logic [2:0]  CLASS_DIAG   = 3'h7;
  localparam logic [4:0]  OP_TEST_RDY  = 5'h00;
  localparam logic [4:0]  OP_RECAL     = 5'h01;
  localparam logic [4:0]  OP_SENSE     = 5'h03;
  localparam int unsigned CTL_HALF_A   = 0;
  localparam int unsigned CTL_HALF_B   = 1;
  localparam int unsigned CTL_BUF_STEP = 2;
  localparam int unsigned CTL_NO_REREAD = 6;
  localparam int unsigned CTL_NO_RETRY = 7;

  // ---------------------------------------------------------------
  // Status and sense fields
  // ---------------------------------------------------------------
  localparam int unsigned ST_ERR_BIT   = 1;
  localparam int unsigned ST_UNIT_BIT  = 5;
  localparam int unsigned SN_VALID_BIT = 7;
  localparam logic [5:0]  ERR_NONE     = 6'h00;
  localparam logic [5:0]  ERR_NOT_RDY  = 6'h04;
  localparam logic [5:0]  ERR_NO_TRK0  = 6'h06;
  localparam logic [5:0]  ERR_INVALID  = 6'h20;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned STEP_PULSE_US = 200;
  localparam int unsigned STEP_PULSE_CYC = STEP_PULSE_US * CLK_MHZ;
  localparam int unsigned STEP_GAP_CYC = 2;
  localparam logic [15:0] MAX_STEPS    = 16'h0400;

  typedef struct packed {
    logic [2:0]  cmd_class;
    logic [4:0]  opcode;
    logic [2:0]  drive_unit_number;
    logic [20:0] block_addr;
    logic [7:0]  count;
    logic [7:0]  control;
  } dcbd_cmd_type;

  typedef struct packed {
    logic       half_step_a;
    logic       half_step_b;
    logic       buffered;
    logic       no_reread;
    logic       no_retry;
  } dcbd_opt_type;

endpackage

// ==== logic/dcbd_stepper.sv ====
// Step pulse generator driving the head arm toward track 00
module dcbd_stepper #(
  parameter int unsigned PULSE_CYC = dcbd_pkg::STEP_PULSE_CYC
) (
  input  wire logic                clk_i,      // System clock
  input  wire logic                arst_n_i,   // Async reset, low
  input  wire logic                start_i,    // Begin seek to track 00
  input  wire dcbd_pkg::dcbd_opt_type opt_i,   // Stepping options
  input  wire logic                track0_i,   // Drive at track 00
  output logic                     step_o,     // Step pulse
  output logic                     busy_o,     // Seek in progress
  output logic                     done_o,     // Pulse: track 00 reached
  output logic                     fail_o      // Pulse: track 00 not reached
);

  typedef enum logic [1:0] {
    SP_IDLE  = 2'b00,
    SP_PULSE = 2'b01,
    SP_GAP   = 2'b10
  } dcbd_sp_type;

  dcbd_sp_type sp_q;
  logic [31:0] tmr_q;
  logic [15:0] steps_q;
  logic [31:0] pulse_len;
  logic        tmr_end;
  logic        limit;

  // Buffered stepping uses the long pulse; other variants a short one
  assign pulse_len = opt_i.buffered ? 32'(PULSE_CYC) : 32'(dcbd_pkg::STEP_GAP_CYC);
  assign tmr_end   = (tmr_q == 32'h0000_0000);
  assign limit     = (steps_q == dcbd_pkg::MAX_STEPS);
  assign step_o    = (sp_q == SP_PULSE);
  assign busy_o    = (sp_q != SP_IDLE);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sp_q    <= SP_IDLE;
      tmr_q   <= 32'h0000_0000;
      steps_q <= 16'h0000;
      done_o  <= 1'b0;
      fail_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      fail_o <= 1'b0;
      if (!tmr_end) begin
        tmr_q <= tmr_q - 32'h0000_0001;
      end
      case (sp_q)
        SP_IDLE: begin
          if (start_i) begin
            steps_q <= 16'h0000;
            if (track0_i) begin
              done_o <= 1'b1;
            end else begin
              sp_q  <= SP_PULSE;
              tmr_q <= pulse_len - 32'h0000_0001;
            end
          end
        end
        SP_PULSE: begin
          if (tmr_end) begin
            sp_q    <= SP_GAP;
            tmr_q   <= 32'(dcbd_pkg::STEP_GAP_CYC);
            steps_q <= steps_q + 16'h0001;
          end
        end
        SP_GAP: begin
          if (tmr_end) begin
            if (track0_i) begin
              sp_q   <= SP_IDLE;
              done_o <= 1'b1;
            end else if (limit) begin
              sp_q   <= SP_IDLE;
              fail_o <= 1'b1;
            end else begin
              sp_q  <= SP_PULSE;
              tmr_q <= pulse_len - 32'h0000_0001;
            end
          end
        end
        default: sp_q <= SP_IDLE;
      endcase
    end
  end

endmodule

// ==== test/dcbd_decoder_asserts.sv ====
// Port-level assertions of the disk command block decoder
module dcbd_decoder_asserts (
  input wire logic                   clk_i,       // Clock
  input wire logic                   arst_n_i,    // Reset, low
  input wire logic                   cmd_valid_i, // Byte offered
  input wire logic [7:0]             cmd_byte_i,  // Command byte
  input wire logic                   cmd_ready_o, // Byte taken
  input wire logic                   out_valid_o, // Reply offered
  input wire logic [7:0]             out_byte_o,  // Reply byte
  input wire logic                   out_sense_o, // Sense byte
  input wire logic                   out_last_o,  // Last reply
  input wire logic                   out_ready_i, // Reply taken
  input wire dcbd_pkg::dcbd_cmd_type cmd_o,       // Decoded block
  input wire dcbd_pkg::dcbd_opt_type opt_o,       // Options
  input wire logic                   drive_sel_o, // Drive
  input wire logic                   step_o,      // Step pulse
  input wire logic                   cmd_busy_o   // Busy
);
  logic [2:0] take_q;
  logic [2:0] take_d;
  logic [2:0] sense_q;
  logic [2:0] sense_d;
  wire        cmd_take = cmd_valid_i && cmd_ready_o;
  wire        out_take = out_valid_o && out_ready_i;
  wire        st0_up   = out_valid_o && !out_sense_o && !out_last_o;
  // Byte index and sense bytes taken
  assign take_d  = !cmd_take ? take_q : (take_q == 3'h5) ? 3'h0 : take_q + 3'h1;
  assign sense_d = (out_take && out_last_o) ? 3'h0 :
                   (out_take && out_sense_o) ? sense_q + 3'h1 : sense_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      take_q  <= 3'h0;
      sense_q <= 3'h0;
    end else begin
      take_q  <= take_d;
      sense_q <= sense_d;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_block_done;
    cmd_take && take_q == 3'h5;
  endsequence
  sequence s_status0_taken;
    out_take && !out_sense_o && !out_last_o;
  endsequence
  AST_BUSY_REFUSE: assert property (cmd_busy_o |-> !cmd_ready_o)
    else $error("command byte accepted while busy");
  AST_CAPTURE: assert property (s_block_done |=> cmd_busy_o && cmd_o.control == $past(cmd_byte_i))
    else $error("control byte not captured");
  AST_HOLD: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_byte_o))
    else $error("reply byte dropped before taken");
  AST_LAST_NEXT: assert property (s_status0_taken |=> out_valid_o && out_last_o)
    else $error("second status byte missing");
  AST_ST1_ZERO: assert property (out_valid_o && out_last_o |-> out_byte_o == 8'h00)
    else $error("second status byte not zero");
  AST_ST0_FMT: assert property (st0_up |-> (out_byte_o & 8'hDD) == 8'h00 && out_byte_o[5] == cmd_o.drive_unit_number[0])
    else $error("first status byte malformed");
  AST_BAD_CLASS: assert property (st0_up && !(cmd_o.cmd_class inside {3'h0, 3'h7}) |-> out_byte_o[1])
    else $error("reserved class not refused");
  AST_SENSE_FOUR: assert property (out_take && out_last_o |-> sense_q == 3'h0 || sense_q == 3'h4)
    else $error("sense byte count wrong");
  AST_OPT_MAP: assert property (opt_o == {cmd_o.control[0], cmd_o.control[1], cmd_o.control[2], cmd_o.control[6], cmd_o.control[7]})
    else $error("control options misdecoded");
  AST_DRIVE_SEL: assert property (drive_sel_o == cmd_o.drive_unit_number[0])
    else $error("drive select wrong");
  AST_STEP_BUSY: assert property (step_o |-> cmd_busy_o)
    else $error("step pulse outside a command");
endmodule

bind dcbd_decoder dcbd_decoder_asserts u_asserts (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i),
  .cmd_ready_o(cmd_ready_o), .out_valid_o(out_valid_o), .out_byte_o(out_byte_o),
  .out_sense_o(out_sense_o), .out_last_o(out_last_o), .out_ready_i(out_ready_i),
  .cmd_o(cmd_o), .opt_o(opt_o), .drive_sel_o(drive_sel_o), .step_o(step_o),
  .cmd_busy_o(cmd_busy_o)
);

// ==== test/dcbd_host_model.sv ====
// Host adapter model: sends command blocks, collects replies
module dcbd_host_model (
  input  wire logic       clk_i,       // Clock
  input  wire logic       cmd_ready_i, // Byte taken
  input  wire logic       out_valid_i, // Reply offered
  input  wire logic [7:0] out_byte_i,  // Reply byte
  input  wire logic       out_last_i,  // Last reply
  output logic            cmd_valid_o, // Byte offered
  output logic [7:0]      cmd_byte_o,  // Command byte
  output logic            out_ready_o  // Reply taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rep [$];
  initial begin
    cmd_valid_o = 1'h0;
    cmd_byte_o  = 8'hA5;
    out_ready_o = 1'h0;
  end
  // Six bytes, byte 0 first, each held until taken
  task automatic send(input logic [47:0] blk);
    for (int i = 5; i >= 0; i--) begin
      cmd_valid_o <= 1'h1;
      cmd_byte_o  <= blk[i*8 +: 8];
      do @(posedge clk_i); while (!cmd_ready_i);
    end
    cmd_valid_o <= 1'h0;
    cmd_byte_o  <= ~blk[7:0];
  endtask
  task automatic collect(input logic slow);
    logic done;
    done = 1'h0;
    rep.delete();
    out_ready_o <= 1'h1;
    while (!done) begin
      @(posedge clk_i);
      if (out_valid_i && out_ready_o) begin
        rep.push_back(out_byte_i);
        done = out_last_i;
        if (slow && !done) begin
          out_ready_o <= 1'h0;
          repeat (2) @(posedge clk_i);
          out_ready_o <= 1'h1;
        end
      end
    end
    out_ready_o <= 1'h0;
  endtask
endmodule

// ==== test/dcbd_decoder_test.sv ====
// Self-checking bench of the disk command block decoder
module dcbd_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   clk_i;
  logic                   arst_n_i;
  logic                   cmd_valid;
  logic [7:0]             cmd_byte;
  logic                   cmd_ready;
  logic                   out_valid;
  logic [7:0]             out_byte;
  logic                   out_sense;
  logic                   out_last;
  logic                   out_ready;
  logic                   drive_ready;
  logic                   xfer_err;
  logic [20:0]            xfer_addr;
  logic                   track0;
  logic                   step;
  dcbd_pkg::dcbd_cmd_type cmd;
  dcbd_pkg::dcbd_opt_type opt;
  int                     errors;
  int                     tests_run;
  int                     cycles;
  int                     steps;
  int                     hi_n;
  int                     target;
  logic [7:0]             rep [$];

  dcbd_decoder DUT (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid), .cmd_byte_i(cmd_byte),
    .cmd_ready_o(cmd_ready), .out_valid_o(out_valid), .out_byte_o(out_byte),
    .out_sense_o(out_sense), .out_last_o(out_last), .out_ready_i(out_ready),
    .drive_ready_i(drive_ready), .track0_i(track0), .xfer_err_i(xfer_err),
    .xfer_addr_i(xfer_addr), .cmd_o(cmd), .opt_o(opt), .drive_sel_o(),
    .step_o(step), .cmd_busy_o()
  );
  dcbd_host_model host (
    .clk_i(clk_i), .cmd_ready_i(cmd_ready), .out_valid_i(out_valid), .out_byte_i(out_byte),
    .out_last_i(out_last), .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte),
    .out_ready_o(out_ready)
  );

  // Drive: reaches track 00 after target steps
  assign track0 = steps >= target;
  initial clk_i = 1'h0;
  always #5 clk_i = ~clk_i;
  always @(posedge step) steps <= steps + 1;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (step) hi_n <= hi_n + 1;
    if (cycles == 32'h0000EA60) begin
      errors = errors + 1;
      complete_run();
    end
  end

  task automatic complete_run;
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [47:0] blk(input logic [2:0] c, input logic [4:0] op, input logic d,
                                      input logic [20:0] a, input logic [7:0] n,
                                      input logic [7:0] ctl);
    return {c, op, 2'h0, d, a, n, ctl};
  endfunction
  function automatic logic [20:0] lba(input int cylinder_index, input int heads_per_cylinder,
                                      input int head_index, input int sectors_per_track,
                                      input int sector_index);
    return 21'((cylinder_index * heads_per_cylinder + head_index) * sectors_per_track
               + sector_index);
  endfunction
  task automatic run(input logic [47:0] b, input logic slow);
    host.send(b);
    host.collect(slow);
    rep = host.rep;
  endtask
  task automatic sense(input logic d);
    run(blk(3'h0, 5'h03, d, 21'h1FFFFF, 8'hFF, 8'h00), 1'h0);
    check("sense length", rep.size(), 32'h6);
    check("sense status", rep[4], {2'h0, d, 5'h00});
    check("sense end", rep[5], 8'h00);
  endtask

  task automatic t_ready;
    logic [7:0] ctl;
    for (int i = 0; i < 5; i++) begin
      ctl = 8'h01 << ((i > 2) ? i + 3 : i);
      drive_ready <= i[0];
      run(blk(3'h0, 5'h00, i[1], lba(1500, 8, 5, 32, 7), 8'hB7, ctl), i[2]);
      check("class", cmd.cmd_class, 3'h0);
      check("opcode", cmd.opcode, 5'h00);
      check("unit", cmd.drive_unit_number, {2'h0, i[1]});
      check("address", cmd.block_addr, 21'h05DCA7);
      check("count", cmd.count, 8'hB7);
      check("options", opt, {ctl[0], ctl[1], ctl[2], ctl[6], ctl[7]});
      check("status", rep[0], {2'h0, i[1], 3'h0, !i[0], 1'h0});
      check("end status", rep[1], 8'h00);
      if (!i[0]) begin
        sense(i[1]);
        check("sense code", rep[0], 8'h04);
      end
    end
  endtask
  task automatic t_invalid;
    for (int j = 0; j < 8; j++) begin
      run(blk(j[2:0], (j == 0) ? 5'h02 : 5'h00, 1'h1, 21'h0, 8'h00, 8'h00), j[0]);
      check("refused", rep[0], 8'h22);
      sense(1'h1);
      check("sense code", rep[0], 8'h20);
    end
  endtask
  task automatic t_addr;
    xfer_addr <= 21'h15A3C7;
    xfer_err  <= 1'h1;
    @(posedge clk_i);
    xfer_err  <= 1'h0;
    sense(1'h0);
    check("sense high", rep[1], 8'h15);
    check("sense mid", rep[2], 8'hA3);
    check("sense low", rep[3], 8'hC7);
  endtask
  task automatic recal(input logic [7:0] ctl, input int tgt, input logic d);
    steps = 0;
    hi_n = 0;
    target = tgt;
    run(blk(3'h0, 5'h01, d, 21'h0, 8'h00, ctl), 1'h0);
  endtask
  task automatic t_recal;
    drive_ready <= 1'h1;
    recal(8'h80, 32'h3, 1'h1);
    check("steps", steps, 32'h3);
    check("pulse time", hi_n, 32'h6);
    check("status", rep[0], 8'h20);
    recal(8'h04, 32'h1, 1'h0);
    check("buffered pulse", hi_n, dcbd_pkg::STEP_PULSE_CYC);
    check("status", rep[0], 8'h00);
    recal(8'h01, 32'h100000, 1'h0);
    check("no track 00", rep[0], 8'h02);
    sense(1'h0);
    check("sense code", rep[0], 8'h06);
  endtask

  initial begin
    arst_n_i = 1'h0;
    drive_ready = 1'h0;
    xfer_err = 1'h0;
    xfer_addr = 21'h0;
    steps = 0;
    hi_n = 0;
    target = 0;
    cycles = 0;
    errors = 0;
    tests_run = 0;
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'h1;
    @(posedge clk_i);
    t_ready();
    t_invalid();
    t_addr();
    t_recal();
    complete_run();
  end
endmodule
